// *** rtl/floppy_drive_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic [11:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Lanes of the host byte actually driven on the last read
   output logic [7:0] read_driven_o,
   // Static decode configuration
   input wire logic external_decode_i,
   input wire logic swap_drives_i,
   // Disk interface
   output logic [3:0] drv_pick_n_o,
   output logic [3:0] spindle_on_n_o,
   output logic ctrl_reset_o,
   output logic dma_enable_o,
   output logic [1:0] tape_pick_o
);

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire logic req;
   wire logic hit_control;
   wire logic hit_tape;
   wire logic hit_status;
   wire logic wr_lane0;
   wire logic wr_control;
   wire logic wr_tape;

   assign req = cyc_i && stb_i && !ack_o;
   assign hit_control = (adr_i == drive_decode_pkg::DRIVE_CONTROL_ADDR);
   assign hit_tape = (adr_i == drive_decode_pkg::TAPE_DRIVE_SELECT_ADDR);
   assign hit_status = (adr_i == drive_decode_pkg::PIN_STATUS_ADDR);
   assign wr_lane0 = req && we_i && sel_i[0];
   assign wr_control = wr_lane0 && hit_control;
   assign wr_tape = wr_lane0 && hit_tape;

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] drive_control_q;
   logic [7:0] drive_control_d;
   logic [1:0] tape_drive_select_q;
   logic [1:0] tape_drive_select_d;

   assign drive_control_d = wr_control ? dat_i[7:0] : drive_control_q;
   assign tape_drive_select_d = wr_tape ?
      dat_i[drive_decode_pkg::TAPE_PICK_LO_BIT +: 2] : tape_drive_select_q;

   // Only the hardware reset clears these; soft reset bit has no hold here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_control_q <= drive_decode_pkg::DRIVE_CONTROL_RESET;
         tape_drive_select_q <= drive_decode_pkg::TAPE_DRIVE_SELECT_RESET;
      end else begin
         drive_control_q <= drive_control_d;
         tape_drive_select_q <= tape_drive_select_d;
      end
   end

   // -----------------------------------------------------------------
   // Drive decode
   // -----------------------------------------------------------------
   drive_decode_pkg::decode_cfg_type cfg;
   drive_decode_pkg::drive_pins_type pins;

   assign cfg.external = external_decode_i;
   assign cfg.swapped = swap_drives_i;

   drive_pick_decode u_decode (
      .drive_control_i(drive_control_q),
      .cfg_i(cfg),
      .pins_o(pins)
   );

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   wire logic [31:0] rd_data;
   wire logic [7:0] rd_driven;
   wire logic [31:0] status_word;

   assign status_word = {22'h000000, cfg.swapped, cfg.external,
                         spindle_on_n_o, drv_pick_n_o};
   assign rd_data = hit_control ? {24'h000000, drive_control_q} :
                    hit_tape ? {30'h00000000, tape_drive_select_q} :
                    hit_status ? status_word :
                    32'h00000000;
   assign rd_driven = hit_tape ? drive_decode_pkg::TAPE_READ_DRIVEN :
                      drive_decode_pkg::FULL_READ_DRIVEN;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         read_driven_o <= drive_decode_pkg::FULL_READ_DRIVEN;
      end else begin
         ack_o <= req;
         if (req && !we_i) begin
            dat_o <= rd_data;
            read_driven_o <= rd_driven;
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Tape selection goes out as a plain level; inside, only the bus readback reads it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_pick_n_o <= drive_decode_pkg::ALL_HIGH;
         spindle_on_n_o <= drive_decode_pkg::ALL_HIGH;
         ctrl_reset_o <= 1'b1;
         dma_enable_o <= 1'b0;
         tape_pick_o <= drive_decode_pkg::TAPE_DRIVE_SELECT_RESET;
      end else begin
         drv_pick_n_o <= pins.pick_n;
         spindle_on_n_o <= pins.spindle_n;
         ctrl_reset_o <= !drive_control_q[drive_decode_pkg::SOFT_RESET_N_BIT];
         dma_enable_o <= drive_control_q[drive_decode_pkg::DMA_ENABLE_BIT];
         tape_pick_o <= tape_drive_select_q;
      end
   end

endmodule
`default_nettype wire

// *** rtl/drive_decode_pkg.sv ***
// What this block does
// - Tape register at index 3F3 reads and writes but steers no internal logic.
// - Controller software reset leaves the tape register contents unchanged.
// - Tape register read drives only data bits 0 and 1; bits 2-7 undriven.
// - Tape pick bits: 00 none, 01 drive 1, 10 drive 2, 11 drive 3.
// - Internal normal: pick output of field goes low only if its motor bit set.
// - Internal normal: each spindle output is the inverse of motor bits 4 to 7.
// - Internal swapped: pick outputs 0 and 1 swap; spindle 0/1 from bits 5/4.
// - External normal: pick lines carry field; spindle 0 low if selected motor set.
// - External swapped: codes 00 and 01 exchanged on pick lines; spindle as normal.
// - Control bits 1:0 give the drive number; bits 7:4 enable motors 0 to 3.
package drive_decode_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [9:0] DRIVE_CONTROL_IDX = 10'h3f2;
   localparam logic [9:0] TAPE_DRIVE_SELECT_IDX = 10'h3f3;
   localparam logic [9:0] PIN_STATUS_IDX = 10'h3f0;
   localparam logic [11:0] DRIVE_CONTROL_ADDR = {DRIVE_CONTROL_IDX, 2'b00};
   localparam logic [11:0] TAPE_DRIVE_SELECT_ADDR = {TAPE_DRIVE_SELECT_IDX, 2'b00};
   localparam logic [11:0] PIN_STATUS_ADDR = {PIN_STATUS_IDX, 2'b00};

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam int DRIVE_NUMBER_LSB = 0;
   localparam int SOFT_RESET_N_BIT = 2;
   localparam int DMA_ENABLE_BIT = 3;
   localparam int SPINDLE_ENABLE_LSB = 4;
   localparam int TAPE_PICK_LO_BIT = 0;
   localparam int TAPE_PICK_HI_BIT = 1;
   localparam logic [7:0] DRIVE_CONTROL_RESET = 8'h00;
   localparam logic [1:0] TAPE_DRIVE_SELECT_RESET = 2'h0;
   localparam logic [7:0] TAPE_READ_DRIVEN = 8'h03;
   localparam logic [7:0] FULL_READ_DRIVEN = 8'hff;
   localparam logic [3:0] ALL_HIGH = 4'hf;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic external;
      logic swapped;
   } decode_cfg_type;

   typedef struct packed {
      logic [3:0] pick_n;
      logic [3:0] spindle_n;
   } drive_pins_type;

endpackage

// *** rtl/drive_pick_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_pick_decode (
   input wire logic [7:0] drive_control_i,
   input wire drive_decode_pkg::decode_cfg_type cfg_i,
   output drive_decode_pkg::drive_pins_type pins_o
);

   // -----------------------------------------------------------------
   // Field extraction
   // -----------------------------------------------------------------
   wire logic [1:0] number;
   wire logic [3:0] spindle_enable;
   wire logic sel_motor;
   wire logic [1:0] swapped_number;
   wire logic [1:0] out_number;
   wire logic [3:0] onehot;

   assign number = drive_control_i[drive_decode_pkg::DRIVE_NUMBER_LSB +: 2];
   assign spindle_enable = drive_control_i[drive_decode_pkg::SPINDLE_ENABLE_LSB +: 4];
   assign sel_motor = spindle_enable[number];
   // Drives 0 and 1 exchange places, 2 and 3 pass
   assign swapped_number = (number[1] == 1'b0) ? {1'b0, ~number[0]} : number;
   assign out_number = cfg_i.swapped ? swapped_number : number;

   // -----------------------------------------------------------------
   // Per-drive select decode
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_onehot
         assign onehot[g] = sel_motor && (out_number == 2'(g));
      end
   endgenerate

   // -----------------------------------------------------------------
   // Output selection
   // -----------------------------------------------------------------
   wire logic [3:0] int_pick_n;
   wire logic [3:0] int_spindle_n;
   wire logic [3:0] ext_pick_n;
   wire logic [3:0] ext_spindle_n;

   assign int_pick_n = ~onehot;
   assign int_spindle_n = cfg_i.swapped ?
      {~spindle_enable[3:2], ~spindle_enable[0], ~spindle_enable[1]} :
      ~spindle_enable;
   assign ext_pick_n = {2'b11, out_number};
   assign ext_spindle_n = {3'b111, ~sel_motor};

   assign pins_o.pick_n = cfg_i.external ? ext_pick_n : int_pick_n;
   assign pins_o.spindle_n = cfg_i.external ? ext_spindle_n : int_spindle_n;

endmodule
`default_nettype wire

// *** rtl/dummy_unused_placeholder_never.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/drive_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_ctrl_chk (
   input wire logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o,
   input wire logic external_decode_i, swap_drives_i, ctrl_reset_o, dma_enable_o,
   input wire logic [11:0] adr_i,
   input wire logic [31:0] dat_i, dat_o,
   input wire logic [3:0] sel_i, drv_pick_n_o, spindle_on_n_o,
   input wire logic [7:0] read_driven_o,
   input wire logic [1:0] tape_pick_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = cyc_i && stb_i && !ack_o;
   wire tape_wr = req && we_i && sel_i[0] && adr_i == 12'hfcc;
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
   a_ack_answer: assert property (req |=> ack_o) else $error("no ack");
   a_reset_idle: assert property ($past(rst_i) |-> {drv_pick_n_o, spindle_on_n_o} == 8'hff)
      else $error("outputs not idle after reset");
   a_pick_single: assert property (!$past(external_decode_i) |-> $countones(~drv_pick_n_o) <= 1)
      else $error("several drives picked");
   a_pick_spins: assert property (!$past(external_decode_i) |->
      (~drv_pick_n_o & spindle_on_n_o) == 4'h0) else $error("pick without motor");
   a_ext_unused: assert property ($past(external_decode_i) |->
      drv_pick_n_o[3:2] == 2'h3 && spindle_on_n_o[3:1] == 3'h7) else $error("ext lines");
   a_tape_read: assert property (req && !we_i && adr_i == 12'hfcc |=>
      read_driven_o == 8'h03 && dat_o[31:2] == 30'h0) else $error("tape read lanes");
   a_tape_pick: assert property (tape_wr |=> ##1 tape_pick_o == $past(dat_i[1:0], 2))
      else $error("tape pick value");
   a_tape_inert: assert property (tape_wr |=> ##1
      $stable(drv_pick_n_o) && $stable(spindle_on_n_o)) else $error("tape moved drives");
endmodule
bind floppy_drive_ctrl drive_ctrl_chk chk (.clk_i, .rst_i, .we_i, .cyc_i, .stb_i, .ack_o,
   .external_decode_i, .swap_drives_i, .ctrl_reset_o, .dma_enable_o, .adr_i, .dat_i,
   .dat_o, .sel_i, .drv_pick_n_o, .spindle_on_n_o, .read_driven_o, .tape_pick_o);
`default_nettype wire

// *** tb/drive_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_bank (
   input wire logic external_i,
   input wire logic [3:0] pick_n_i,
   input wire logic [3:0] spindle_n_i,
   output logic [3:0] spinning_o
);
   // Drives both selected and spinning
   assign spinning_o = external_i ? (spindle_n_i[0] ? 4'h0 : 4'h1 << pick_n_i[1:0])
      : ~pick_n_i & ~spindle_n_i;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic external_decode_i = 1'b0, swap_drives_i = 1'b0;
   logic [11:0] adr_i = 12'h0;
   logic [31:0] dat_i = 32'h0, q;
   logic [3:0] sel_i = 4'h0;
   wire logic [31:0] dat_o;
   wire logic ack_o, ctrl_reset_o, dma_enable_o;
   wire logic [7:0] read_driven_o;
   wire logic [3:0] drv_pick_n_o, spindle_on_n_o, spinning;
   wire logic [1:0] tape_pick_o;
   int n_mismatch = 0, checks_done = 0;
   always #5 clk_i = ~clk_i;
   floppy_drive_ctrl dut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i,
      .dat_o, .ack_o, .read_driven_o, .external_decode_i, .swap_drives_i, .drv_pick_n_o,
      .spindle_on_n_o, .ctrl_reset_o, .dma_enable_o, .tape_pick_o);
   drive_bank bank (.external_i(external_decode_i), .pick_n_i(drv_pick_n_o),
      .spindle_n_i(spindle_on_n_o), .spinning_o(spinning));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int i;
      @(posedge clk_i);
      adr_i <= a;
      we_i <= w;
      dat_i <= {24'h0, d};
      sel_i <= 4'h1;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      i = 0;
      do begin @(posedge clk_i); i++; end while (ack_o !== 1'b1 && i < 20);
      if (i >= 20) begin n_mismatch++; tally_and_finish(); end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   function automatic logic [7:0] exp_pins(input logic e, s, input logic [7:0] c);
      logic [1:0] f, g;
      logic [3:0] p, sp;
      f = c[1:0];
      g = f ^ {1'b0, s & ~f[1]};
      p = 4'hf;
      sp = ~c[7:4];
      if (e) begin
         p = {2'h3, g};
         sp = {3'h7, ~c[4 + f]};
      end else begin
         if (c[4 + f]) p[g] = 1'b0;
         if (s) sp[1:0] = {~c[4], ~c[5]};
      end
      return {p, sp};
   endfunction
   initial begin
      logic [3:0] m;
      logic [7:0] c;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(12'hfc8, 1'b0, 8'h0); `CHK(q, 32'h0)
      wb(12'hfcc, 1'b0, 8'h0); `CHK(q, 32'h0)
      wb(12'hfcc, 1'b1, 8'hff);
      wb(12'hfcc, 1'b0, 8'h0); `CHK(q, 32'h3)
      `CHK(read_driven_o, 8'h03)
      wb(12'hfc8, 1'b1, 8'h10);
      wb(12'hfcc, 1'b0, 8'h0); `CHK(q, 32'h3)
      `CHK(ctrl_reset_o, 1'b1)
      for (int t = 0; t < 4; t++) begin
         wb(12'hfcc, 1'b1, 8'(t));
         @(posedge clk_i);
         #1 `CHK(tape_pick_o, 2'(t))
      end
      wb(12'hfc8, 1'b1, 8'h08);
      @(posedge clk_i);
      #1 `CHK(dma_enable_o, 1'b1)
      `CHK(ctrl_reset_o, 1'b1)
      wb(12'hfc0, 1'b0, 8'h0); `CHK(q, 32'h000000ff)
      wb(12'h004, 1'b0, 8'h0); `CHK(q, 32'h0)
      for (int k = 0; k < 32; k++) begin
         @(posedge clk_i);
         external_decode_i <= k[4];
         swap_drives_i <= k[3];
         m = 4'h1 << k[2:1];
         c = {k[0] ? ~m : m, 2'h1, k[2:1]};
         wb(12'hfc8, 1'b1, c);
         @(posedge clk_i);
         #1 `CHK({drv_pick_n_o, spindle_on_n_o}, exp_pins(k[4], k[3], c))
         `CHK(spinning, k[0] ? 4'h0 : 4'h1 << (k[2:1] ^ {1'b0, k[3] & ~k[2]}))
         wb(12'hfc8, 1'b0, 8'h0); `CHK(q, {24'h0, c})
         `CHK(read_driven_o, 8'hff)
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
